/* hw/oasr_chan_regs.sv */
// Register array for the eight channels' per-channel byte registers.
// Assumes index decoding is done by the caller.
`timescale 1ns/1ps
`default_nettype none

module oasr_chan_regs
  import oasr_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          clk_en,
  input  wire logic          wr,
  input  wire oasr_chan_type chan,
  input  wire oasr_preg_type idx,
  input  wire logic [7:0]    wmask,
  input  wire oasr_byte_type wdata,
  output var  oasr_byte_type rdata
);

  oasr_byte_type mem [`OASR_NUM_CHAN][`OASR_NUM_PREG];

  function automatic oasr_byte_type reset_of(input int i);
    if (i == int'(oasr_p_rto))
      return `OASR_RTO_RST;
    else if (i == int'(oasr_p_rbs))
      return `OASR_RBS_RST;
    return `OASR_ZERO;
  endfunction : reset_of

  assign rdata = (idx == oasr_p_none) ? `OASR_ZERO : mem[chan][idx];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int c = 0; c < `OASR_NUM_CHAN; c++) begin
        for (int r = 0; r < `OASR_NUM_PREG; r++) begin
          mem[c][r] <= reset_of(r);
        end
      end
    end else if (clk_en && wr && idx != oasr_p_none) begin
      mem[chan][idx] <= (mem[chan][idx] & ~wmask) | (wdata & wmask);
    end
  end

endmodule : oasr_chan_regs

`default_nettype wire

/* hw/oasr_defs.svh */
// Register offsets, reset values and field positions of the register bank.
// Assumes inclusion by bare name from files under hw/.
`ifndef OASR_DEFS_SVH
`define OASR_DEFS_SVH

// ----------------------------------------------------------------------
// Per-channel offsets
// ----------------------------------------------------------------------
`define OASR_CCR_OFF      7'h01
`define OASR_IEN_OFF      7'h02
`define OASR_OPT1_OFF     7'h03
`define OASR_OPT2_OFF     7'h04
`define OASR_OPT3_OFF     7'h05
`define OASR_CSTAT_OFF    7'h06
`define OASR_SC1_OFF      7'h09
`define OASR_SC2_OFF      7'h0a
`define OASR_SC3_OFF      7'h0b
`define OASR_SC4_OFF      7'h0c
`define OASR_MCO1_OFF     7'h10
`define OASR_MCO2_OFF     7'h11
`define OASR_MCF_OFF      7'h12
`define OASR_RTO_OFF      7'h18
`define OASR_MSV_OFF      7'h28
`define OASR_MRTS_OFF     7'h29
`define OASR_MDTR_OFF     7'h2a
`define OASR_RDH_OFF      7'h31
`define OASR_RDL_OFF      7'h32
`define OASR_RBS_OFF      7'h33
`define OASR_TDH_OFF      7'h39
`define OASR_TDL_OFF      7'h3a

// ----------------------------------------------------------------------
// Global offsets
// ----------------------------------------------------------------------
`define OASR_GVEC_OFF     7'h40
`define OASR_GSC1_OFF     7'h41
`define OASR_GSC2_OFF     7'h42
`define OASR_GSC3_OFF     7'h43
`define OASR_MSM_OFF      7'h61
`define OASR_TSM_OFF      7'h62
`define OASR_RSM_OFF      7'h63
`define OASR_CAS_OFF      7'h64
`define OASR_SRS_OFF      7'h65
`define OASR_SRC_OFF      7'h66
`define OASR_FWR_OFF      7'h6b
`define OASR_PPH_OFF      7'h70
`define OASR_PPL_OFF      7'h71
`define OASR_MACK_OFF     7'h75
`define OASR_TACK_OFF     7'h76
`define OASR_RACK_OFF     7'h77

// ----------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------
`define OASR_ZERO         8'h00
`define OASR_RTO_RST      8'h05
`define OASR_RBS_RST      8'h21
`define OASR_FF_RST       8'hff
`define OASR_ACK_RST      8'h80
`define OASR_RTS_BIT      0
`define OASR_DTR_BIT      1
`define OASR_CHAN_LSB     0
`define OASR_CHAN_MSB     2
`define OASR_VEC_TYPE_MSB 2
`define OASR_ACK_MODEM    3'h1
`define OASR_ACK_TX       3'h2
`define OASR_ACK_RX       3'h3
`define OASR_NUM_CHAN     8
`define OASR_NUM_PREG     22

`endif

/* hw/oasr_pin_sync.sv */
// Three-stage synchroniser for a pin level; change taken when the
// second and third stages agree.
// Assumes one clock and an active-low synchronous reset.
`timescale 1ns/1ps
`default_nettype none

module oasr_pin_sync
  import oasr_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] pin,
  output var  logic [W-1:0] level
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  wire  [W-1:0] agree = ~(stage2 ^ stage3);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else if (clk_en) begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= (agree & stage3) | (~agree & level);
    end
  end

endmodule : oasr_pin_sync

`default_nettype wire

/* hw/oasr_pkg.sv */
// Types shared by the register bank files.
// Assumes oasr_defs.svh is reachable by bare name.
`include "oasr_defs.svh"

package oasr_pkg;

  typedef logic [7:0] oasr_byte_type;
  typedef logic [2:0] oasr_chan_type;

  // One host access as seen after the pin stage
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } oasr_req_type;

  typedef enum logic [4:0] {
    oasr_p_ccr, oasr_p_ien, oasr_p_opt1, oasr_p_opt2, oasr_p_opt3,
    oasr_p_cstat, oasr_p_sc1, oasr_p_sc2, oasr_p_sc3, oasr_p_sc4,
    oasr_p_mco1, oasr_p_mco2, oasr_p_mcf, oasr_p_rto, oasr_p_msv,
    oasr_p_rdh, oasr_p_rdl, oasr_p_rbs, oasr_p_tdh, oasr_p_tdl,
    oasr_p_none
  } oasr_preg_type;

  typedef enum {oasr_idle, oasr_busy} oasr_state_type;

endpackage : oasr_pkg

/* hw/oasr_regbank.sv */
// Host register bank of an eight-channel serial controller.
// Assumes a byte-wide asynchronous host bus: chip select, read and
// write strobes (active low), 7-bit address, split data in/out/enable.
// Functional notes
// [RULE_01] Writes accepted everywhere, read-only included
// [RULE_02] 16-bit host: device A0 on host A1
// [RULE_03] Big-endian 16-bit host drives A0 high
// [RULE_04] Little-endian 16-bit host drives A0 low
// [RULE_05] 32-bit host: device A0 on host A2
// [RULE_06] Option registers at 03-05, reset zero
// [RULE_07] Read-only control status at 06, reset zero
// [RULE_08] Receive timeout at 18, reset five
// [RULE_09] Rx divisors 31/32, tx 39/3A, zero
// [RULE_10] Special characters at 09 to 0C
// [RULE_11] Modem change options 10/11, flags 12
// [RULE_12] Modem value 28; 29/2A alias RTS/DTR
// [RULE_13] Modem value register reads back, reset zero
// [RULE_14] Global registers shared by all channels
// [RULE_15] Polled host acknowledges by reading ack register
// [RULE_16] Channel select low bits steer channel access
// [RULE_17] Ack registers return modified interrupt vector
`timescale 1ns/1ps
`default_nettype none

module oasr_regbank
  import oasr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       cs_b,
  input  wire logic       rd_b,
  input  wire logic       wr_b,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] data_in,
  output var  logic [7:0] data_out,
  output var  logic       data_oe,
  output var  logic [2:0] chan_sel,
  output var  logic [7:0] srv_config
);

  // --------------------------------------------------------------------
  // Pin stage
  // --------------------------------------------------------------------
  // Strobes and bus pass the synchroniser so address and data settle
  // before the strobe edge is acted on.
  logic [$bits(oasr_req_type)-1:0] pins_sync;
  oasr_req_type req;
  oasr_req_type req_q;

  oasr_pin_sync #(.W($bits(oasr_req_type))) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .pin     ({~cs_b & ~rd_b, ~cs_b & ~wr_b, addr, data_in}),
    .level   (pins_sync)
  );

  assign req = oasr_req_type'(pins_sync);

  wire rd_start = req.rd & ~req_q.rd;
  wire wr_start = req.wr & ~req_q.wr;

  // --------------------------------------------------------------------
  // Global registers
  // --------------------------------------------------------------------
  // Arbitrary revision value; software may overwrite it.
  localparam oasr_byte_type FW_REV = 8'h5a;

  oasr_byte_type g_vec, g_sc1, g_sc2, g_sc3, g_msm, g_tsm, g_rsm;
  oasr_byte_type g_cas, g_src, g_fwr, g_pph, g_ppl, g_srs;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] o);
    return a == o;
  endfunction : hit

  // --------------------------------------------------------------------
  // Per-channel decode
  // --------------------------------------------------------------------
  oasr_preg_type pidx;
  logic [7:0]    pmask;

  always_comb begin
    pidx  = oasr_p_none;
    pmask = 8'hff;
    case (req.addr)
      `OASR_CCR_OFF:   pidx = oasr_p_ccr;
      `OASR_IEN_OFF:   pidx = oasr_p_ien;
      `OASR_OPT1_OFF:  pidx = oasr_p_opt1; // RULE_06
      `OASR_OPT2_OFF:  pidx = oasr_p_opt2; // RULE_06
      `OASR_OPT3_OFF:  pidx = oasr_p_opt3; // RULE_06
      `OASR_CSTAT_OFF: pidx = oasr_p_cstat; // RULE_07
      `OASR_SC1_OFF:   pidx = oasr_p_sc1; // RULE_10
      `OASR_SC2_OFF:   pidx = oasr_p_sc2; // RULE_10
      `OASR_SC3_OFF:   pidx = oasr_p_sc3; // RULE_10
      `OASR_SC4_OFF:   pidx = oasr_p_sc4; // RULE_10
      `OASR_MCO1_OFF:  pidx = oasr_p_mco1; // RULE_11
      `OASR_MCO2_OFF:  pidx = oasr_p_mco2; // RULE_11
      `OASR_MCF_OFF:   pidx = oasr_p_mcf; // RULE_11
      `OASR_RTO_OFF:   pidx = oasr_p_rto; // RULE_08
      `OASR_MSV_OFF:   pidx = oasr_p_msv; // RULE_13
      `OASR_MRTS_OFF: begin
        pidx  = oasr_p_msv; // RULE_12
        pmask = 8'h01 << `OASR_RTS_BIT;
      end
      `OASR_MDTR_OFF: begin
        pidx  = oasr_p_msv; // RULE_12
        pmask = 8'h01 << `OASR_DTR_BIT;
      end
      `OASR_RDH_OFF:   pidx = oasr_p_rdh; // RULE_09
      `OASR_RDL_OFF:   pidx = oasr_p_rdl; // RULE_09
      `OASR_RBS_OFF:   pidx = oasr_p_rbs;
      `OASR_TDH_OFF:   pidx = oasr_p_tdh; // RULE_09
      `OASR_TDL_OFF:   pidx = oasr_p_tdl; // RULE_09
      default:         pidx = oasr_p_none;
    endcase
  end

  wire oasr_chan_type cur_chan = g_cas[`OASR_CHAN_MSB:`OASR_CHAN_LSB];
  wire is_alias = hit(req.addr, `OASR_MRTS_OFF) ||
                  hit(req.addr, `OASR_MDTR_OFF);
  oasr_byte_type prdata;

  oasr_chan_regs u_chan (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .wr      (wr_start), // RULE_01
    .chan    (cur_chan), // RULE_16
    .idx     (pidx),
    .wmask   (pmask),
    .wdata   (req.wdata),
    .rdata   (prdata)
  );

  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  // Ack reads return the vector with the request class in its low bits.
  function automatic oasr_byte_type ack_vec(input logic [2:0] cls);
    return {g_vec[7:3], cls};
  endfunction : ack_vec

  wire g_hit = (req.addr >= `OASR_GVEC_OFF);
  oasr_byte_type grdata;

  always_comb begin
    case (req.addr)
      `OASR_GVEC_OFF:   grdata = g_vec; // RULE_14
      `OASR_GSC1_OFF:   grdata = g_sc1;
      `OASR_GSC2_OFF:   grdata = g_sc2;
      `OASR_GSC3_OFF:   grdata = g_sc3;
      `OASR_MSM_OFF:    grdata = g_msm;
      `OASR_TSM_OFF:    grdata = g_tsm;
      `OASR_RSM_OFF:    grdata = g_rsm;
      `OASR_CAS_OFF:    grdata = g_cas;
      `OASR_SRS_OFF:    grdata = g_srs;
      `OASR_SRC_OFF:    grdata = g_src;
      `OASR_FWR_OFF:    grdata = g_fwr;
      `OASR_PPH_OFF:    grdata = g_pph;
      `OASR_PPL_OFF:    grdata = g_ppl;
      `OASR_MACK_OFF:   grdata = ack_vec(`OASR_ACK_MODEM); // RULE_17
      `OASR_TACK_OFF:   grdata = ack_vec(`OASR_ACK_TX); // RULE_17
      `OASR_RACK_OFF:   grdata = ack_vec(`OASR_ACK_RX); // RULE_17
      default:          grdata = `OASR_ZERO;
    endcase
  end

  // Aliases are write-only and read as zero.
  wire oasr_byte_type next_rdata = g_hit ? grdata :
                                   is_alias ? `OASR_ZERO : prdata;

  // --------------------------------------------------------------------
  // Global register writes
  // --------------------------------------------------------------------
  // Status register is writable too: no protection in hardware, so
  // software must leave it alone.
  wire gw = wr_start & g_hit; // RULE_01

  wire we_vec = gw && hit(req.addr, `OASR_GVEC_OFF); // RULE_14
  wire we_sc1 = gw && hit(req.addr, `OASR_GSC1_OFF);
  wire we_sc2 = gw && hit(req.addr, `OASR_GSC2_OFF);
  wire we_sc3 = gw && hit(req.addr, `OASR_GSC3_OFF);
  wire we_msm = gw && hit(req.addr, `OASR_MSM_OFF);
  wire we_tsm = gw && hit(req.addr, `OASR_TSM_OFF);
  wire we_rsm = gw && hit(req.addr, `OASR_RSM_OFF);
  wire we_cas = gw && hit(req.addr, `OASR_CAS_OFF); // RULE_16
  wire we_srs = gw && hit(req.addr, `OASR_SRS_OFF); // RULE_01
  wire we_src = gw && hit(req.addr, `OASR_SRC_OFF);
  wire we_fwr = gw && hit(req.addr, `OASR_FWR_OFF);
  wire we_pph = gw && hit(req.addr, `OASR_PPH_OFF);
  wire we_ppl = gw && hit(req.addr, `OASR_PPL_OFF);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_vec <= `OASR_FF_RST;
    end else if (clk_en && we_vec) begin
      g_vec <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_sc1 <= `OASR_ZERO;
    end else if (clk_en && we_sc1) begin
      g_sc1 <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_sc2 <= `OASR_ZERO;
    end else if (clk_en && we_sc2) begin
      g_sc2 <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_sc3 <= `OASR_ZERO;
    end else if (clk_en && we_sc3) begin
      g_sc3 <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_msm <= `OASR_ZERO;
    end else if (clk_en && we_msm) begin
      g_msm <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_tsm <= `OASR_ZERO;
    end else if (clk_en && we_tsm) begin
      g_tsm <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_rsm <= `OASR_ZERO;
    end else if (clk_en && we_rsm) begin
      g_rsm <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_cas <= `OASR_ZERO;
    end else if (clk_en && we_cas) begin
      g_cas <= req.wdata; // RULE_16
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_srs <= `OASR_ZERO;
    end else if (clk_en && we_srs) begin
      g_srs <= req.wdata; // RULE_01
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_src <= `OASR_ZERO;
    end else if (clk_en && we_src) begin
      g_src <= req.wdata;
    end
  end

  // Revision byte is plain storage; only reset restores it.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_fwr <= FW_REV;
    end else if (clk_en && we_fwr) begin
      g_fwr <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_pph <= `OASR_FF_RST;
    end else if (clk_en && we_pph) begin
      g_pph <= req.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      g_ppl <= `OASR_FF_RST;
    end else if (clk_en && we_ppl) begin
      g_ppl <= req.wdata;
    end
  end

  // --------------------------------------------------------------------
  // Bus outputs
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      req_q <= '0;
    end else if (clk_en) begin
      req_q <= req;
    end
  end

  // Read data is caught once per read so a slow host sees it steady.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      data_out <= `OASR_ZERO;
    end else if (clk_en && rd_start) begin
      data_out <= next_rdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      data_oe <= 1'b0;
    end else if (clk_en) begin
      data_oe <= req.rd;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      chan_sel <= 3'h0;
    end else if (clk_en) begin
      chan_sel <= cur_chan;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      srv_config <= `OASR_ZERO;
    end else if (clk_en) begin
      srv_config <= g_src;
    end
  end

endmodule : oasr_regbank

`default_nettype wire

/* testbench/oasr_host.sv */
// Host model: byte accesses on the strobe bus of the register bank.
// Assumes strobes are seen by the device within five cycles.
`timescale 1ns/1ps
`default_nettype none

module oasr_host (
  input  wire logic       clk_sys,
  output var  logic       cs_b,
  output var  logic       rd_b,
  output var  logic       wr_b,
  output var  logic [6:0] addr,
  output var  logic [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  // ------
  // Access
  // ------
  initial begin
    cs_b = 1'b1;
    rd_b = 1'b1;
    wr_b = 1'b1;
    addr = 7'h00;
    data_in = 8'h00;
  end

  // Lane bits of the host address never reach the device; sh is one
  // on a 16-bit host and two on a 32-bit host without byte steering
  task automatic acc(input logic w, input logic [7:0] ha, input int sh,
                     input logic [7:0] wd, output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    addr = 7'(ha >> sh);
    data_in = w ? wd : ~data_in;
    repeat (4) @(posedge clk_sys);
    #1;
    cs_b = 1'b0;
    rd_b = w;
    wr_b = !w;
    repeat (8) @(posedge clk_sys);
    #1;
    q = (data_oe === 1'b1) ? data_out : 8'hxx;
    cs_b = 1'b1;
    rd_b = 1'b1;
    wr_b = 1'b1;
    data_in = ~data_in;
    repeat (6) @(posedge clk_sys);
  endtask : acc
endmodule : oasr_host

`default_nettype wire

/* testbench/oasr_regbank_chk.sv */
// Checker on the register bank ports.
// Assumes the host holds each strobe for eight cycles or more.
`timescale 1ns/1ps
`default_nettype none

module oasr_regbank_chk (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       clk_en,
  input wire logic       cs_b,
  input wire logic       rd_b,
  input wire logic       wr_b,
  input wire logic [6:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic [2:0] chan_sel,
  input wire logic [7:0] srv_config
);
  // ----------
  // Properties
  // ----------
  wire logic rd_act;
  wire logic wr_act;
  assign rd_act = !cs_b && !rd_b;
  assign wr_act = !cs_b && !wr_b;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  reset_clear_a: assert property (disable iff (1'b0)
    !rst_b && clk_en |=> !data_oe && chan_sel == 3'h0 && srv_config == 8'h00)
    else $error("outputs not cleared by reset");
  oe_cause_a: assert property (
    $rose(data_oe) |-> $past(rd_act, 1) && $past(rd_act, 3))
    else $error("data_oe rose without a read");
  oe_hold_a: assert property (
    data_oe && rd_act && clk_en |=> data_oe)
    else $error("data_oe dropped during a read");
  oe_drop_a: assert property (
    $fell(rd_act) |-> ##[1:6] !data_oe)
    else $error("data_oe not released");
  oe_idle_a: assert property (
    (!rd_act) [*6] |-> !data_oe)
    else $error("data_oe high while idle");
  dout_cause_a: assert property (
    !$stable(data_out) |-> $past(rd_act))
    else $error("data_out changed without a read");
  chan_write_a: assert property (
    !$stable(chan_sel) |-> $past(wr_act) && $past(addr) == 7'h64
      && chan_sel == $past(data_in[2:0]))
    else $error("channel number changed wrongly");
  srv_write_a: assert property (
    !$stable(srv_config) |-> $past(wr_act) && $past(addr) == 7'h66
      && srv_config == $past(data_in))
    else $error("service config changed wrongly");

  cover property ($rose(data_oe));
  cover property (!$stable(chan_sel));
  cover property (!$stable(srv_config));
endmodule : oasr_regbank_chk

bind oasr_regbank oasr_regbank_chk oasr_regbank_chk_i (.clk_sys, .rst_b,
  .clk_en, .cs_b, .rd_b, .wr_b, .addr, .data_in, .data_out, .data_oe,
  .chan_sel, .srv_config);

`default_nettype wire

/* testbench/oasr_regbank_test.sv */
// Self-checking bench of the register bank through the host model.
// Assumes a big-endian 16-bit host: offset on A1, lane bit high.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("wrong value %s exp %h got %h", nm, e, g); \
  end \
end

module oasr_regbank_test
  import oasr_pkg::*;
;
  // -----
  // Setup
  // -----
  logic            clk_sys = 1'b0;
  logic            rst_b = 1'b0;
  logic            clk_en = 1'b1;
  wire logic       cs_b, rd_b, wr_b, data_oe;
  wire logic [6:0] addr;
  wire logic [7:0] data_in, data_out, srv_config;
  wire logic [2:0] chan_sel;
  int              err_total = 0;
  int              n_checks = 0;
  // Arbitrary revision code
  localparam logic [7:0] REV = 8'h5a;
  logic [6:0] offs [18] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h09,
    7'h0a, 7'h0b, 7'h0c, 7'h10, 7'h11, 7'h12, 7'h18, 7'h28, 7'h31,
    7'h32, 7'h39, 7'h3a};
  logic [6:0] goffs [9] = '{7'h41, 7'h42, 7'h43, 7'h61, 7'h62, 7'h63,
    7'h64, 7'h65, 7'h66};

  always #4 clk_sys = ~clk_sys;

  oasr_regbank oasr_regbank_i (.clk_sys, .rst_b, .clk_en, .cs_b, .rd_b,
    .wr_b, .addr, .data_in, .data_out, .data_oe, .chan_sel, .srv_config);
  oasr_host oasr_host_i (.clk_sys, .cs_b, .rd_b, .wr_b, .addr,
    .data_in, .data_out, .data_oe);

  task automatic wr(input logic [6:0] o, input logic [7:0] d);
    logic [7:0] q;
    oasr_host_i.acc(1'b1, {o, 1'b1}, 1, d, q);
  endtask : wr

  task automatic rdc(input logic [6:0] o, input logic [7:0] e);
    logic [7:0] q;
    oasr_host_i.acc(1'b0, {o, 1'b1}, 1, 8'h00, q);
    `CHK($sformatf("offset %h", o), e, q)
  endtask : rdc

  // ---------
  // Scenarios
  // ---------
  task automatic t_reset;
    foreach (offs[i])
      rdc(offs[i], offs[i] == 7'h18 ? 8'h05 : 8'h00);
    rdc(7'h06, 8'h00);
    rdc(7'h33, 8'h21);
    rdc(7'h40, 8'hff);
    rdc(7'h70, 8'hff);
    rdc(7'h71, 8'hff);
    foreach (goffs[i]) rdc(goffs[i], 8'h00);
    rdc(7'h6b, REV);
  endtask : t_reset

  // Two channels written in turn so steering faults overwrite each other
  task automatic t_channels;
    logic [2:0] ch [2] = '{3'h3, 3'h5};
    foreach (ch[k]) begin
      wr(7'h64, {5'h00, ch[k]});
      `CHK("chan_sel", ch[k], chan_sel)
      foreach (offs[i]) wr(offs[i], {offs[i][5:0], ch[k][2:1]});
    end
    foreach (ch[k]) begin
      wr(7'h64, {5'h00, ch[k]});
      foreach (offs[i])
        rdc(offs[i], {offs[i][5:0], ch[k][2:1]});
    end
  endtask : t_channels

  task automatic t_readonly;
    wr(7'h06, 8'ha5);
    rdc(7'h06, 8'ha5);
    wr(7'h7e, 8'h55);
    rdc(7'h7e, 8'h00);
  endtask : t_readonly

  task automatic t_alias;
    wr(7'h28, 8'h00);
    wr(7'h29, 8'hff);
    rdc(7'h28, 8'h01);
    wr(7'h2a, 8'hff);
    rdc(7'h28, 8'h03);
    wr(7'h29, 8'hfe);
    rdc(7'h28, 8'h02);
    rdc(7'h29, 8'h00);
  endtask : t_alias

  task automatic t_global;
    wr(7'h64, 8'h01);
    wr(7'h41, 8'h5c);
    wr(7'h64, 8'h06);
    rdc(7'h41, 8'h5c);
    wr(7'h40, 8'ha8);
    rdc(7'h75, 8'ha9);
    rdc(7'h76, 8'haa);
    rdc(7'h77, 8'hab);
    rdc(7'h40, 8'ha8);
    wr(7'h66, 8'h3c);
    `CHK("srv_config", 8'h3c, srv_config)
  endtask : t_global

  // Little-endian 16-bit and unsteered 32-bit hosts reach the same bytes
  task automatic t_lanes;
    logic [7:0] q;
    oasr_host_i.acc(1'b1, {7'h09, 1'b0}, 1, 8'h6e, q);
    rdc(7'h09, 8'h6e);
    oasr_host_i.acc(1'b1, {6'h0b, 2'b11}, 2, 8'h71, q);
    oasr_host_i.acc(1'b0, {6'h0b, 2'b00}, 2, 8'h00, q);
    `CHK("wide host read", 8'h71, q)
    rdc(7'h0b, 8'h71);
  endtask : t_lanes

  // Strobes given while the clock enable is low must leave no trace
  task automatic t_freeze;
    @(posedge clk_sys);
    #1;
    clk_en = 1'b0;
    wr(7'h41, 8'h96);
    wr(7'h64, 8'h02);
    #1;
    clk_en = 1'b1;
    `CHK("chan_sel", 3'h6, chan_sel)
    rdc(7'h41, 8'h5c);
  endtask : t_freeze

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_channels();
    t_readonly();
    t_alias();
    t_lanes();
    t_global();
    t_freeze();
    complete_run();
  end
endmodule : oasr_regbank_test

`default_nettype wire
